// ==== rtl/ext_irq_edge_filter.sv ====
/*
 * Input conditioning and request generation for external interrupt pins four and five:
 * synchronisers, mode-dependent sampling strobes, noise filters, trigger decode and
 * the filtered-level capture for pin four.
 * Assumes clock is the gear clock, op_mode and the write strobes come from logic on
 * the same clock, and the pins and the low-frequency clock are asynchronous inputs.
 * Request enables and latches live in the core and are not here.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - pin-four trigger: 00 rising, 01 falling, 10 both edges, 11 high level
// - every pin-four request captures the filtered pin level into a readable bit
// - under both-edge trigger, captured level shows which edge made the request
// - fast modes: pin-four level accepted after three consecutive equal samples, else noise
// - pin-four sample interval: every gear clock, divided by 4, 8 or 16
// - low-speed modes: sample on low-frequency clock by 4, two equal samples
// - deep wait, deep halt, stop: no sampling, no requests; resumes afterwards
// - pin-five requests come only from falling edges
// - fast modes: pin five rejects one-cycle pulses, passes two-cycle pulses
// - low-speed modes: pin five rejects under four, passes eight slow periods
// - per-pin clock enable resets to zero and blocks the pin until set
module ext_irq_edge_filter
    import ext_irq_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ext_irq_pin_four,
    input wire logic ext_irq_pin_five,
    input wire logic low_freq_clock,
    input wire logic [2:0] op_mode,
    input wire logic pin_four_irq_control_write,
    input wire logic [1:0] pin_four_trigger_select,
    input wire logic [1:0] pin_four_filter_interval,
    input wire logic power_gate_control_write,
    input wire logic [1:0] irq_clock_enable,
    output logic [1:0] pin_four_trigger_state,
    output logic [1:0] pin_four_interval_state,
    output logic [1:0] irq_clock_enable_state,
    output logic pin_four_filtered_level,
    output logic pin_four_request,
    output logic pin_five_request
);

    // ==========================================================
    // mode decode
    function automatic logic mode_fast(input logic [2:0] m);
        case (op_mode_t'(m))
            fast_run_mode, fast_wait_mode: mode_fast = 1'b1;
            default: mode_fast = 1'b0;
        endcase
    endfunction

    function automatic logic mode_slow(input logic [2:0] m);
        case (op_mode_t'(m))
            low_speed_run_mode, low_speed_wait_mode: mode_slow = 1'b1;
            default: mode_slow = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // configuration
    logic [1:0] trig_q, trig_d;
    logic [1:0] ivl_q, ivl_d;
    logic [1:0] clk_en_q, clk_en_d;

    always_comb begin
        trig_d = trig_q;
        ivl_d = ivl_q;
        clk_en_d = clk_en_q;
        if (pin_four_irq_control_write) begin
            trig_d = pin_four_trigger_select;
            ivl_d = pin_four_filter_interval;
        end
        if (power_gate_control_write) begin
            clk_en_d = irq_clock_enable;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trig_q <= TRIGGER_RESET;
            ivl_q <= INTERVAL_RESET;
            clk_en_q <= CLOCK_ENABLE_RESET;
        end else begin
            trig_q <= trig_d;
            ivl_q <= ivl_d;
            clk_en_q <= clk_en_d;
        end
    end

    // ==========================================================
    // synchronisers: bit 0 pin four, bit 1 pin five, bit 2 low-frequency clock
    logic [2:0] raw;
    logic [2:0] sync1_q, sync2_q, sync3_q;
    logic [2:0] clean_q, clean_d;

    assign raw = {low_freq_clock, ext_irq_pin_five, ext_irq_pin_four};

    // a change counts only once stages two and three agree
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            clean_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : clean_q[i];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_q <= {1'b0, PIN_FIVE_IDLE, PIN_FOUR_IDLE};
            sync2_q <= {1'b0, PIN_FIVE_IDLE, PIN_FOUR_IDLE};
            sync3_q <= {1'b0, PIN_FIVE_IDLE, PIN_FOUR_IDLE};
            clean_q <= {1'b0, PIN_FIVE_IDLE, PIN_FOUR_IDLE};
        end else begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            clean_q <= clean_d;
        end
    end

    // ==========================================================
    // sample strobes
    logic [3:0] gear_div_q, gear_div_d;
    logic lf_prev_q, lf_prev_d;
    logic [1:0] lf_div_q, lf_div_d;
    logic lf_rise;
    logic lf_tick;
    logic ivl_tick;
    logic fast_now, slow_now;
    logic s4_en, s5_en;

    assign fast_now = mode_fast(op_mode);
    assign slow_now = mode_slow(op_mode);
    assign lf_rise = clean_q[2] && !lf_prev_q;
    assign lf_tick = lf_rise && (lf_div_q == LF_DIV_LAST);

    always_comb begin
        gear_div_d = 4'(gear_div_q + 4'h1);
        lf_prev_d = clean_q[2];
        lf_div_d = lf_rise ? 2'(lf_div_q + 2'h1) : lf_div_q;
        case (ivl_q)
            IVL_DIV1: ivl_tick = 1'b1;
            IVL_DIV4: ivl_tick = (gear_div_q[1:0] == 2'h3);
            IVL_DIV8: ivl_tick = (gear_div_q[2:0] == 3'h7);
            IVL_DIV16: ivl_tick = (gear_div_q == 4'hF);
            default: ivl_tick = 1'b0;
        endcase
        // deep modes get no strobe, so the filters freeze until a run mode returns
        s4_en = 1'b0;
        s5_en = 1'b0;
        if (fast_now) begin
            s4_en = clk_en_q[0] && ivl_tick;
            s5_en = clk_en_q[1];
        end else if (slow_now) begin
            s4_en = clk_en_q[0] && lf_tick;
            s5_en = clk_en_q[1] && lf_tick;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gear_div_q <= 4'h0;
            lf_prev_q <= 1'b0;
            lf_div_q <= 2'h0;
        end else begin
            gear_div_q <= gear_div_d;
            lf_prev_q <= lf_prev_d;
            lf_div_q <= lf_div_d;
        end
    end

    // ==========================================================
    // noise filters
    logic f4_level, f5_level;
    logic [1:0] need4, need5;

    assign need4 = fast_now ? FAST_SAMPLES : SLOW_SAMPLES;
    assign need5 = fast_now ? PIN_FIVE_FAST_SAMPLES : SLOW_SAMPLES;

    level_filter #(
        .IDLE_LEVEL(PIN_FOUR_IDLE)
    ) u_filter_four (
        .clock(clock),
        .rst(rst),
        .sample_en(s4_en),
        .need_count(need4),
        .din(clean_q[0]),
        .level(f4_level)
    );

    level_filter #(
        .IDLE_LEVEL(PIN_FIVE_IDLE)
    ) u_filter_five (
        .clock(clock),
        .rst(rst),
        .sample_en(s5_en),
        .need_count(need5),
        .din(clean_q[1]),
        .level(f5_level)
    );

    // ==========================================================
    // request generation
    logic f4_prev_q, f4_prev_d;
    logic f5_prev_q, f5_prev_d;
    logic req4_q, req4_d;
    logic req5_q, req5_d;
    logic cap_q, cap_d;
    logic run_now;
    logic hit4;

    assign run_now = fast_now || slow_now;

    always_comb begin
        f4_prev_d = f4_level;
        f5_prev_d = f5_level;
        case (trig_q)
            TRIG_RISE: hit4 = f4_level && !f4_prev_q;
            TRIG_FALL: hit4 = !f4_level && f4_prev_q;
            TRIG_BOTH: hit4 = f4_level != f4_prev_q;
            TRIG_HIGH: hit4 = f4_level;
            default: hit4 = 1'b0;
        endcase
        req4_d = run_now && clk_en_q[0] && hit4;
        req5_d = run_now && clk_en_q[1] && !f5_level && f5_prev_q;
        // a request freezes the level it was raised on for software to read
        cap_d = req4_d ? f4_level : cap_q;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            f4_prev_q <= PIN_FOUR_IDLE;
            f5_prev_q <= PIN_FIVE_IDLE;
            req4_q <= 1'b0;
            req5_q <= 1'b0;
            cap_q <= PIN_FOUR_IDLE;
        end else begin
            f4_prev_q <= f4_prev_d;
            f5_prev_q <= f5_prev_d;
            req4_q <= req4_d;
            req5_q <= req5_d;
            cap_q <= cap_d;
        end
    end

    assign pin_four_trigger_state = trig_q;
    assign pin_four_interval_state = ivl_q;
    assign irq_clock_enable_state = clk_en_q;
    assign pin_four_filtered_level = cap_q;
    assign pin_four_request = req4_q;
    assign pin_five_request = req5_q;

    // ==========================================================
    // checks
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    chk_rise_trigger: assert property (
        req4_q && $past(trig_q) == TRIG_RISE |-> $past(f4_level) && !$past(f4_prev_q))
        else $error("rising trigger request without rising edge");
    chk_fall_trigger: assert property (
        req4_q && $past(trig_q) == TRIG_FALL |-> !$past(f4_level) && $past(f4_prev_q))
        else $error("falling trigger request without falling edge");
    chk_both_edges: assert property (
        trig_q == TRIG_BOTH && run_now && clk_en_q[0] && f4_level != f4_prev_q
        |=> req4_q && cap_q == $past(f4_level))
        else $error("both-edge request or its level missing");
    chk_level_capture: assert property (req4_q |-> cap_q == $past(f4_level))
        else $error("captured level differs from filtered level");
    chk_high_hold: assert property (
        trig_q == TRIG_HIGH && run_now && clk_en_q[0] && f4_level |=> req4_q)
        else $error("high-level request dropped while level high");
    chk_deep_quiet: assert property (
        !run_now |-> !s4_en && !s5_en ##1 !req4_q && !req5_q)
        else $error("activity in a deep mode");
    chk_gate_off: assert property (
        !clk_en_q[0] |-> !s4_en ##1 !req4_q)
        else $error("pin four active with its clock gated");
    chk_interval_16: assert property (
        fast_now && ivl_q == IVL_DIV16 && s4_en |-> gear_div_q == 4'hF)
        else $error("divide-by-16 strobe off its slot");
    chk_interval_4: assert property (
        fast_now && ivl_q == IVL_DIV4 && s4_en |-> gear_div_q[1:0] == 2'h3)
        else $error("divide-by-4 strobe off its slot");
    chk_slow_rate: assert property (
        slow_now && (s4_en || s5_en) |-> clean_q[2] && !lf_prev_q && lf_div_q == LF_DIV_LAST)
        else $error("slow-mode sample not on quarter low-frequency clock");
    chk_five_fall: assert property (
        req5_q |-> $past(f5_prev_q) && !$past(f5_level))
        else $error("pin five request without falling edge");
    chk_five_fast: assert property (
        fast_now && clk_en_q[1] |-> s5_en && need5 == 2'h2)
        else $error("pin five fast filter not two gear cycles");

endmodule

`default_nettype wire

// ==== rtl/ext_irq_pkg.sv ====
/*
 * Shared constants for the pin-four / pin-five external interrupt conditioning block:
 * trigger and interval encodings, operating modes, reset values and timing counts.
 * Assumes the block's clock is the gear clock at 10 MHz.
 */
package ext_irq_pkg;

    // ==========================================================
    // clock and timing
    localparam int GEAR_PERIOD_NS = 100;
    // shortest pin-five pulse that must pass in fast modes
    localparam int PIN_FIVE_PASS_NS = 200;
    localparam logic [1:0] PIN_FIVE_FAST_SAMPLES =
        2'((PIN_FIVE_PASS_NS + GEAR_PERIOD_NS - 1) / GEAR_PERIOD_NS);
    // equal samples needed before a level is accepted
    localparam logic [1:0] FAST_SAMPLES = 2'h3;
    localparam logic [1:0] SLOW_SAMPLES = 2'h2;
    // last count of the divide-by-4 low-frequency clock counter for slow-mode sampling
    localparam logic [1:0] LF_DIV_LAST = 2'h3;

    // ==========================================================
    // trigger select field
    localparam logic [1:0] TRIG_RISE = 2'h0;
    localparam logic [1:0] TRIG_FALL = 2'h1;
    localparam logic [1:0] TRIG_BOTH = 2'h2;
    localparam logic [1:0] TRIG_HIGH = 2'h3;

    // ==========================================================
    // filter interval field
    localparam logic [1:0] IVL_DIV1 = 2'h0;
    localparam logic [1:0] IVL_DIV4 = 2'h1;
    localparam logic [1:0] IVL_DIV8 = 2'h2;
    localparam logic [1:0] IVL_DIV16 = 2'h3;

    // ==========================================================
    // reset values
    localparam logic [1:0] TRIGGER_RESET = 2'h0;
    localparam logic [1:0] INTERVAL_RESET = 2'h0;
    localparam logic [1:0] CLOCK_ENABLE_RESET = 2'h0;
    localparam logic PIN_FOUR_IDLE = 1'b0;
    localparam logic PIN_FIVE_IDLE = 1'b1;

    // ==========================================================
    // operating modes
    typedef enum logic [2:0] {
        fast_run_mode = 3'h0,
        fast_wait_mode = 3'h1,
        low_speed_run_mode = 3'h2,
        low_speed_wait_mode = 3'h3,
        deep_wait_mode = 3'h4,
        deep_halt_mode = 3'h5,
        stop_mode = 3'h6
    } op_mode_t;

endpackage

// ==== rtl/level_filter.sv ====
/*
 * Consecutive-sample noise filter: accepts a new level once the input has been
 * seen equal on need_count successive sample strobes.
 * Assumes din is already synchronised to clock and sample_en is high one cycle per sample, or held high to sample every cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module level_filter #(
    parameter logic IDLE_LEVEL = 1'b0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic sample_en,
    input wire logic [1:0] need_count,
    input wire logic din,
    output logic level
);

    logic last_q, last_d;
    logic [1:0] cnt_q, cnt_d;
    logic level_q, level_d;

    // ==========================================================
    // sample run counter
    always_comb begin
        last_d = last_q;
        cnt_d = cnt_q;
        level_d = level_q;
        if (sample_en) begin
            if (din == last_q) begin
                cnt_d = (cnt_q == 2'h3) ? cnt_q : 2'(cnt_q + 2'h1);
            end else begin
                last_d = din;
                cnt_d = 2'h1;
            end
            if (cnt_d >= need_count) begin
                level_d = din;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            last_q <= IDLE_LEVEL;
            cnt_q <= 2'h0;
            level_q <= IDLE_LEVEL;
        end else begin
            last_q <= last_d;
            cnt_q <= cnt_d;
            level_q <= level_d;
        end
    end

    assign level = level_q;

    // ==========================================================
    // checks
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    chk_level_only_sampled: assert property ($changed(level_q) |-> $past(sample_en))
        else $error("filtered level moved without a sample strobe");
    chk_three_equal: assert property (
        sample_en && need_count == 2'h3 && din == last_q && cnt_q == 2'h2
        |=> level_q == $past(din))
        else $error("third equal sample did not set level");
    chk_two_equal: assert property (
        sample_en && need_count == 2'h2 && din == last_q && cnt_q != 2'h0
        |=> level_q == $past(din))
        else $error("second equal sample did not set level");
    chk_single_reject: assert property (
        sample_en && din != last_q && need_count != 2'h1 |=> $stable(level_q))
        else $error("single differing sample changed level");

endmodule

`default_nettype wire

// ==== tb/irq_pin_source.sv ====
/*
 * External signal source for the two interrupt pins, plus the free-running
 * low-frequency crystal clock.
 * Assumes the bench sets the wanted pin levels; pins are push-pull driven.
 */
`timescale 1ns/1ps
`default_nettype none

module irq_pin_source #(
    parameter int LF_HALF_NS = 2500
) (
    input wire logic level_four,
    input wire logic level_five,
    output logic pin_four,
    output logic pin_five,
    output logic low_freq_clock
);
    // ==========================================================
    // crystal clock, phase unrelated to the gear clock
    logic lf_q = 1'b0;
    always #(LF_HALF_NS) lf_q = ~lf_q;
    assign low_freq_clock = lf_q;

    // ==========================================================
    // pulse widths are chosen by the bench to suit the filter interval
    assign pin_four = level_four;
    // pin five idles high; driven low only while the bench sets level_five low
    assign pin_five = level_five;
endmodule

`default_nettype wire

// ==== tb/test_ext_irq_edge_filter.sv ====
/*
 * Self-checking bench for the pin-four / pin-five request conditioning block.
 * Assumes a 10 MHz gear clock and the pin source model in irq_pin_source.
 */
`timescale 1ns/1ps
`default_nettype none

module test_ext_irq_edge_filter;
    import ext_irq_pkg::*;
    localparam int LF_HALF_NS = 2500;
    localparam int LF_CYC = 2 * LF_HALF_NS / GEAR_PERIOD_NS;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic level_four = PIN_FOUR_IDLE;
    logic level_five = PIN_FIVE_IDLE;
    logic pin_four, pin_five, low_freq_clock;
    logic [2:0] op_mode = 3'h0;
    logic cfg_wr = 1'b0;
    logic pg_wr = 1'b0;
    logic [1:0] trig = 2'h0;
    logic [1:0] ivl = 2'h0;
    logic [1:0] en = 2'h0;
    logic [1:0] trig_st, ivl_st, en_st;
    logic lvl, req4, req5;
    int n_fail = 0;
    int samples_checked = 0;
    int cnt4 = 0;
    int cnt5 = 0;
    int hold;
    int div;

    always #50 clock = ~clock;

    irq_pin_source #(.LF_HALF_NS(LF_HALF_NS)) i_irq_pin_source (
        .level_four(level_four), .level_five(level_five), .pin_four(pin_four),
        .pin_five(pin_five), .low_freq_clock(low_freq_clock));

    ext_irq_edge_filter i_ext_irq_edge_filter (
        .clock(clock), .rst(rst), .ext_irq_pin_four(pin_four),
        .ext_irq_pin_five(pin_five), .low_freq_clock(low_freq_clock),
        .op_mode(op_mode), .pin_four_irq_control_write(cfg_wr),
        .pin_four_trigger_select(trig), .pin_four_filter_interval(ivl),
        .power_gate_control_write(pg_wr), .irq_clock_enable(en),
        .pin_four_trigger_state(trig_st), .pin_four_interval_state(ivl_st),
        .irq_clock_enable_state(en_st), .pin_four_filtered_level(lvl),
        .pin_four_request(req4), .pin_five_request(req5));

    // ==========================================================
    // request pulse counters, seen in the cycle each pulse stands
    always @(posedge clock) begin
        if (req4 === 1'b1) cnt4 <= cnt4 + 1;
        if (req5 === 1'b1) cnt5 <= cnt5 + 1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #10;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic configure(input logic [1:0] t, input logic [1:0] v);
        trig = t;
        ivl = v;
        cfg_wr = 1'b1;
        tick(1);
        cfg_wr = 1'b0;
        tick(1);
        check("trigger_state", 32'(trig_st), 32'(t));
        check("interval_state", 32'(ivl_st), 32'(v));
    endtask

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, n_fail);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // watchdog: the tests need about 6100 cycles
    initial begin
        #4000000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        tick(16);
        check("enable reset", 32'(en_st), 32'(CLOCK_ENABLE_RESET));
        check("request reset", 32'({req4, req5, lvl}), 32'h0);
        rst = 1'b0;
        tick(2);
        configure(TRIG_RISE, IVL_DIV1);
        level_four = 1'b1;
        level_five = 1'b0;
        tick(20);
        level_four = 1'b0;
        level_five = 1'b1;
        tick(20);
        check("gated requests", 32'(cnt4 + cnt5), 32'h0);
        en = 2'h3;
        pg_wr = 1'b1;
        tick(1);
        pg_wr = 1'b0;
        tick(10);
        check("enable state", 32'(en_st), 32'h3);
        end_test("reset_and_gate");

        for (int t = 0; t < 4; t++) begin
            configure(2'(t), IVL_DIV1);
            cnt4 = 0;
            level_four = 1'b1;
            tick(20);
            if (t == TRIG_HIGH) begin
                check("high level held", 32'(req4), 32'h1);
                check("high level cycles", 32'(cnt4 > 8), 32'h1);
            end else begin
                check("rise count", 32'(cnt4), (t == TRIG_FALL) ? 32'h0 : 32'h1);
            end
            if (t != TRIG_FALL) check("level after rise", 32'(lvl), 32'h1);
            // high level: the request stands eight more edges while the filter drains
            hold = cnt4 + ((t == TRIG_FALL || t == TRIG_BOTH) ? 1 : (t == TRIG_HIGH) ? 8 : 0);
            level_four = 1'b0;
            tick(20);
            check("fall count", 32'(cnt4), 32'(hold));
            if (t == TRIG_HIGH) check("high level dropped", 32'(req4), 32'h0);
            if (t == TRIG_FALL || t == TRIG_BOTH) check("level after fall", 32'(lvl), 32'h0);
        end
        end_test("triggers");

        for (int v = 0; v < 4; v++) begin
            div = (v == 0) ? 1 : (2 << v);
            configure(TRIG_RISE, 2'(v));
            cnt4 = 0;
            level_four = 1'b1;
            tick(2 * div);
            level_four = 1'b0;
            tick(6 * div + 10);
            check("short pulse dropped", 32'(cnt4), 32'h0);
            level_four = 1'b1;
            tick(5 * div + 6);
            level_four = 1'b0;
            tick(5 * div + 10);
            check("long pulse taken", 32'(cnt4), 32'h1);
        end
        configure(TRIG_RISE, IVL_DIV1);
        end_test("intervals");

        cnt5 = 0;
        level_five = 1'b0;
        tick(1);
        level_five = 1'b1;
        tick(10);
        check("pin five glitch", 32'(cnt5), 32'h0);
        level_five = 1'b0;
        tick(2);
        level_five = 1'b1;
        tick(10);
        check("pin five fall only", 32'(cnt5), 32'h1);
        end_test("pin_five_fast");

        // code 7 is unused and must behave as a deep mode
        for (int m = 4; m < 8; m++) begin
            op_mode = 3'(m);
            tick(2);
            level_four = 1'b1;
            level_five = 1'b0;
            tick(40);
            level_four = 1'b0;
            level_five = 1'b1;
            tick(40);
        end
        check("deep mode silence", 32'(cnt4 + cnt5), 32'h2);
        end_test("deep_modes");

        for (int m = 2; m < 4; m++) begin
            op_mode = 3'(m);
            tick(12 * LF_CYC);
            cnt4 = 0;
            cnt5 = 0;
            level_four = 1'b1;
            level_five = 1'b0;
            tick(3 * LF_CYC);
            level_four = 1'b0;
            level_five = 1'b1;
            tick(12 * LF_CYC);
            check("slow four short", 32'(cnt4), 32'h0);
            check("slow five short", 32'(cnt5), 32'h0);
            level_four = 1'b1;
            level_five = 1'b0;
            tick(9 * LF_CYC);
            level_four = 1'b0;
            level_five = 1'b1;
            tick(12 * LF_CYC);
            check("slow four long", 32'(cnt4), 32'h1);
            check("slow five long", 32'(cnt5), 32'h1);
        end
        end_test("slow_modes");

        for (int m = 0; m < 2; m++) begin
            op_mode = 3'(m);
            tick(2 + 3 * 1);
            cnt4 = 0;
            level_four = 1'b1;
            tick(20);
            level_four = 1'b0;
            tick(20);
            check("fast resume", 32'(cnt4), 32'h1);
        end
        end_test("fast_resume");
        report_and_stop();
    end
endmodule

`default_nettype wire
